// ==== src/ssc_pkg.sv ====
// Package with constants and carriers for the standalone strap configuration.
package ssc_pkg;

	// ----------------------------------------------------------------
	// Strap decode, reset and clock constants
	// ----------------------------------------------------------------
	localparam logic [3:0] MICROSTEP_RESOLUTION_CODE_8 = 4'h5;
	localparam logic [3:0] MICROSTEP_RESOLUTION_CODE_16 = 4'h4;
	localparam logic [3:0] MICROSTEP_RESOLUTION_CODE_32 = 4'h3;
	localparam logic [3:0] MICROSTEP_RESOLUTION_CODE_64 = 4'h2;
	localparam logic [3:0] MICROSTEP_RESOLUTION_CODE_RESET = 4'h0;
	localparam logic [4:0] RUN_CURRENT_SCALE_RESET = 5'h1f;
	localparam logic [4:0] HOLD_CURRENT_SCALE_RESET = 5'h10;
	localparam logic [3:0] CHOPPER_OFF_TIME_STANDALONE = 4'h3;
	localparam logic [3:0] CHOPPER_OFF_TIME_RESET = 4'h0;
	localparam int WDOG_LIMIT = 32;
	localparam int EDGES_TO_SWITCH = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CLK_INTERNAL = 2'b00,
		CLK_ONE_EDGE = 2'b01,
		CLK_EXTERNAL = 2'b11
	} ssc_clk_e;

	typedef struct packed {
		logic [3:0] microstep_resolution_code;
		logic [4:0] run_current_scale;
		logic [4:0] hold_current_scale;
		logic [3:0] chopper_off_time;
		logic pwm_mode_enable;
	} ssc_cfg_s;

	typedef struct packed {
		logic [6:0] strap;
		logic standalone;
		logic ext_clk;
		ssc_clk_e clk_state;
		logic [5:0] wdog;
		ssc_cfg_s cfg;
		logic diagnostic_output_enable;
	} ssc_state_s;

endpackage

// ==== src/ssc_strap_config.sv ====
// Standalone strap decoder and core clock source selector.
`timescale 1ns/1ps
// Summary of operation
// - Standalone when serial select pin low and step/dir mode pin high.
// - In standalone, four-wire and single-wire serial ports are disabled.
// - In standalone, motion follows step/dir only; ramp generator unused.
// - Straps 1,0 pick microstep code 5, 4, 3 or 2.
// - Straps 4..2 pick run current 16 to 28 in steps of two, or 31.
// - Strap 5 low gives off-time 3; high enables voltage-PWM chopper.
// - Strap 6 low: hold equals run; high: hold is half run.
// - Diagnostic outputs stay as configured before standalone; default off.
// - Reset loads every configuration setting with its default.
// - Clock pin tied low keeps the internal oscillator.
// - Switch to external clock after the second rising edge.
// - Fall back to internal oscillator after 32 cycles without edge.
module ssc_strap_config (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic serial_select_pin,
	input wire logic step_dir_mode_pin,
	input wire logic strap_pin_0,
	input wire logic strap_pin_1,
	input wire logic strap_pin_2,
	input wire logic strap_pin_3,
	input wire logic strap_pin_4,
	input wire logic strap_pin_5,
	input wire logic strap_pin_6,
	input wire logic ext_clk_pin,
	input wire logic serial_cfg_valid,
	input wire ssc_pkg::ssc_cfg_s serial_cfg,
	input wire logic serial_diagnostic_output_enable,
	output ssc_pkg::ssc_cfg_s active_cfg,
	output logic standalone_mode,
	output logic spi_enable,
	output logic uart_enable,
	output logic ramp_generator_enable,
	output logic diagnostic_output_output_enable,
	output logic use_external_clock
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ssc_pkg::ssc_state_s s_q;
	ssc_pkg::ssc_state_s s_d;
	logic ext_rise;
	logic [4:0] run_current_scale_v;

	// Edge of the external clock pin sampled by the core clock. The pin is
	// compared with its registered copy rather than with the next state, so
	// the detector does not feed back through the process that reads it.
	// The registered copy resets low, the idle level of a tied-low pin, so
	// no false edge follows reset.
	assign ext_rise = ext_clk_pin & ~s_q.ext_clk;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Next-state logic: strap decode, mode, clock source and watchdog.
	// One process fills the whole next state so that every field has a
	// single driver and a defined value on every path.
	always_comb
	begin
		s_d = s_q;
		run_current_scale_v = 5'h00;
		s_d.strap = {strap_pin_6, strap_pin_5, strap_pin_4, strap_pin_3,
			strap_pin_2, strap_pin_1, strap_pin_0};
		s_d.ext_clk = ext_clk_pin;
		s_d.standalone = ~serial_select_pin & step_dir_mode_pin;
		// Serial writes only land while the serial ports are alive.
		if (!s_q.standalone && serial_cfg_valid)
		begin
			s_d.cfg = serial_cfg;
			s_d.diagnostic_output_enable = serial_diagnostic_output_enable;
		end
		if (s_q.standalone)
		begin
			case (s_q.strap[1:0])
				2'b00: s_d.cfg.microstep_resolution_code = ssc_pkg::MICROSTEP_RESOLUTION_CODE_8;
				2'b01: s_d.cfg.microstep_resolution_code = ssc_pkg::MICROSTEP_RESOLUTION_CODE_16;
				2'b10: s_d.cfg.microstep_resolution_code = ssc_pkg::MICROSTEP_RESOLUTION_CODE_32;
				default: s_d.cfg.microstep_resolution_code = ssc_pkg::MICROSTEP_RESOLUTION_CODE_64;
			endcase
			if (s_q.strap[4:2] == 3'h7)
				run_current_scale_v = 5'h1f;
			else
				run_current_scale_v = 5'h10 + {1'b0, s_q.strap[4:2], 1'b0};
			s_d.cfg.run_current_scale = run_current_scale_v;
			s_d.cfg.hold_current_scale = s_q.strap[6] ? {1'b0, run_current_scale_v[4:1]}
				: run_current_scale_v;
			if (s_q.strap[5])
				s_d.cfg.pwm_mode_enable = 1'b1;
			else
			begin
				s_d.cfg.pwm_mode_enable = 1'b0;
				s_d.cfg.chopper_off_time = ssc_pkg::CHOPPER_OFF_TIME_STANDALONE;
			end
		end
		// Clock selection; a pin held low never leaves internal.
		// The watchdog counts core cycles since the last rise and stops at
		// its limit, so it cannot wrap back and mask a missing clock.
		// Limitation: the limit is counted in core cycles, not oscillator
		// cycles, so the fallback time scales with the core clock.
		if (ext_rise)
			s_d.wdog = 6'h00;
		else if (s_q.wdog != 6'(ssc_pkg::WDOG_LIMIT))
			s_d.wdog = s_q.wdog + 6'h01;
		case (s_q.clk_state)
			ssc_pkg::CLK_INTERNAL:
				if (ext_rise)
					s_d.clk_state = ssc_pkg::CLK_ONE_EDGE;
			ssc_pkg::CLK_ONE_EDGE:
				if (ext_rise)
					s_d.clk_state = ssc_pkg::CLK_EXTERNAL;
				else if (s_q.wdog == 6'(ssc_pkg::WDOG_LIMIT))
					s_d.clk_state = ssc_pkg::CLK_INTERNAL;
			default:
				if (!ext_rise && s_q.wdog == 6'(ssc_pkg::WDOG_LIMIT))
					s_d.clk_state = ssc_pkg::CLK_INTERNAL;
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// State register; defaults come only from reset.
	// Only constants load in the reset branch, so the asynchronous path
	// never depends on another flop.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q.strap <= 7'h00;
			s_q.standalone <= 1'b0;
			s_q.ext_clk <= 1'b0;
			s_q.clk_state <= ssc_pkg::CLK_INTERNAL;
			s_q.wdog <= 6'h00;
			s_q.cfg.microstep_resolution_code <= ssc_pkg::MICROSTEP_RESOLUTION_CODE_RESET;
			s_q.cfg.run_current_scale <= ssc_pkg::RUN_CURRENT_SCALE_RESET;
			s_q.cfg.hold_current_scale <= ssc_pkg::HOLD_CURRENT_SCALE_RESET;
			s_q.cfg.chopper_off_time <= ssc_pkg::CHOPPER_OFF_TIME_RESET;
			s_q.cfg.pwm_mode_enable <= 1'b0;
			s_q.diagnostic_output_enable <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Outputs come straight from the state flip-flops.
	assign active_cfg = s_q.cfg;
	assign standalone_mode = s_q.standalone;
	assign spi_enable = ~s_q.standalone;
	assign uart_enable = ~s_q.standalone;
	assign ramp_generator_enable = ~s_q.standalone;
	assign diagnostic_output_output_enable = s_q.diagnostic_output_enable;
	assign use_external_clock = (s_q.clk_state == ssc_pkg::CLK_EXTERNAL);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// All checks share the core clock and are off while reset is held.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Mode pins select standalone one cycle later.
	mode_entry_a: assert property (
		!serial_select_pin && step_dir_mode_pin |=> standalone_mode)
		else $error("standalone not entered");

	// Any other pin pair leaves standalone one cycle later.
	mode_exit_a: assert property (
		!(!serial_select_pin && step_dir_mode_pin) |=> !standalone_mode)
		else $error("standalone kept with wrong pins");

	// Both serial ports are off while standalone.
	serial_off_a: assert property (
		standalone_mode |-> !spi_enable && !uart_enable)
		else $error("serial port alive in standalone");

	// A serial write in standalone must not reach a kept setting.
	serial_block_a: assert property (
		standalone_mode && s_q.strap[5] && serial_cfg_valid |=>
		$stable(active_cfg.chopper_off_time))
		else $error("serial write landed in standalone");

	// The ramp generator is off while standalone.
	ramp_off_a: assert property (
		standalone_mode |-> !ramp_generator_enable)
		else $error("ramp generator on in standalone");

	// Straps low and low give the eight-microstep code.
	microstep_resolution_code_decode_a: assert property (
		standalone_mode && $past(standalone_mode) && $stable(s_q.strap)
		&& s_q.strap[1:0] == 2'b00 |=>
		active_cfg.microstep_resolution_code == ssc_pkg::MICROSTEP_RESOLUTION_CODE_8)
		else $error("microstep code wrong");

	// Straps high and high give the 64-microstep code.
	microstep_resolution_code_top_a: assert property (
		standalone_mode && s_q.strap[1:0] == 2'b11 |=>
		active_cfg.microstep_resolution_code == ssc_pkg::MICROSTEP_RESOLUTION_CODE_64)
		else $error("microstep code for high straps wrong");

	// All current straps high give the top run current.
	run_current_scale_top_a: assert property (
		standalone_mode && s_q.strap[4:2] == 3'h7 |=>
		active_cfg.run_current_scale == 5'h1f)
		else $error("run current wrong");

	// All current straps low give the lowest run current.
	run_current_scale_low_a: assert property (
		standalone_mode && s_q.strap[4:2] == 3'h0 |=>
		active_cfg.run_current_scale == 5'h10)
		else $error("lowest run current wrong");

	// Chopper strap low selects the cycle-regulated chopper.
	chopper_sel_a: assert property (
		standalone_mode && !s_q.strap[5] |=>
		active_cfg.chopper_off_time == 4'h3 && !active_cfg.pwm_mode_enable)
		else $error("chopper selection wrong");

	// Chopper strap high enables the voltage-PWM chopper.
	pwm_sel_a: assert property (
		standalone_mode && s_q.strap[5] |=> active_cfg.pwm_mode_enable)
		else $error("voltage chopper not enabled");

	// Hold strap high halves the run current.
	hold_half_a: assert property (
		standalone_mode && s_q.strap[6] |=>
		active_cfg.hold_current_scale ==
		{1'b0, active_cfg.run_current_scale[4:1]})
		else $error("hold current not half");

	// Hold strap low keeps hold current equal to run current.
	hold_equal_a: assert property (
		standalone_mode && !s_q.strap[6] |=>
		active_cfg.hold_current_scale == active_cfg.run_current_scale)
		else $error("hold current not equal to run");

	// Diagnostic enable is frozen once standalone.
	diagnostic_output_keep_a: assert property (
		standalone_mode |=> $stable(diagnostic_output_output_enable))
		else $error("diagnostic_output changed in standalone");

	// Diagnostics change only through a serial write outside standalone.
	diagnostic_output_source_a: assert property (
		!(serial_cfg_valid && !standalone_mode) |=>
		$stable(diagnostic_output_output_enable))
		else $error("diagnostic_output changed without a serial write");

	// A low clock pin never selects the external clock.
	int_hold_a: assert property (
		!use_external_clock && !ext_clk_pin |=> !use_external_clock)
		else $error("external clock chosen without an edge");

	// External clock only after the second rising edge.
	clk_switch_a: assert property (
		!use_external_clock ##1 use_external_clock |->
		$past(s_q.clk_state) == ssc_pkg::CLK_ONE_EDGE)
		else $error("external clock before second edge");

	// The first edge alone never selects the external clock.
	one_edge_a: assert property (
		s_q.clk_state == ssc_pkg::CLK_INTERNAL |=> !use_external_clock)
		else $error("external clock after one edge");

	// Watchdog count never passes its limit.
	wdog_cap_a: assert property (
		s_q.wdog <= 6'(ssc_pkg::WDOG_LIMIT))
		else $error("watchdog count past limit");

	// A missing external clock at the limit falls back next cycle.
	wdog_fall_a: assert property (
		use_external_clock && !ext_rise
		&& s_q.wdog == 6'(ssc_pkg::WDOG_LIMIT) |=> !use_external_clock)
		else $error("watchdog did not fall back");

	// The external clock is kept while the limit is not reached.
	wdog_keep_a: assert property (
		use_external_clock && s_q.wdog != 6'(ssc_pkg::WDOG_LIMIT)
		|=> use_external_clock)
		else $error("external clock dropped early");

	// ----------------------------------------------------------------
	// Cover properties
	// ----------------------------------------------------------------
	// External clock taken and later dropped by the watchdog.
	ext_used_c: cover property (
		use_external_clock ##[1:40] !use_external_clock);

	// Standalone entered from serial mode.
	standalone_c: cover property (!standalone_mode ##1 standalone_mode);

	// Voltage-PWM chopper chosen by its strap.
	pwm_mode_c: cover property (
		standalone_mode && active_cfg.pwm_mode_enable);

	// Serial write that lands before standalone.
	serial_load_c: cover property (
		!standalone_mode && serial_cfg_valid ##1 diagnostic_output_output_enable);

	// Hold current halved by its strap.
	hold_half_c: cover property (
		standalone_mode && s_q.strap[6] ##1
		active_cfg.hold_current_scale != active_cfg.run_current_scale);

endmodule

// ==== testbench/ssc_board_model.sv ====
// Board model: strap levels and an optional external clock source.
`timescale 1ns/1ps
module ssc_board_model (
	input wire logic clock,
	input wire logic [6:0] strap_level,
	input wire logic ext_run,
	output logic [6:0] strap_pins,
	output logic ext_clk_pin
);
	logic [1:0] div_q;

	// Straps start low, as the board holds them during reset.
	initial
	begin
		div_q = 2'h0;
		strap_pins = 7'h00;
		ext_clk_pin = 1'b0;
	end

	// ----------------------------------------------------------------
	// Straps and clock source
	// ----------------------------------------------------------------
	// The clock is the core clock over four (10 MHz, 50 percent duty).
	// A stopped source is held low, which selects the internal oscillator.
	always @(negedge clock)
	begin
		strap_pins <= strap_level;
		div_q <= ext_run ? div_q + 2'h1 : 2'h0;
		ext_clk_pin <= ext_run & div_q[1];
	end
endmodule

// ==== testbench/ssc_strap_config_bench.sv ====
// Self-checking bench for the standalone strap configuration block.
`timescale 1ns/1ps
module ssc_strap_config_bench;
	typedef struct packed {
		logic [6:0] strap;
		ssc_pkg::ssc_cfg_s exp;
	} ssc_row_s;
	logic clock, reset_n, serial_select_pin, step_dir_mode_pin, ext_run;
	logic serial_cfg_valid, serial_diagnostic_output_enable, ext_clk_pin;
	logic standalone_mode, spi_enable, uart_enable, ramp_generator_enable;
	logic diagnostic_output_output_enable, use_external_clock;
	logic [6:0] strap_level, sp;
	ssc_pkg::ssc_cfg_s serial_cfg, active_cfg;
	ssc_row_s rows[8];
	logic [4:0] run_current_scale_tab[8] = '{5'h10, 5'h12, 5'h14, 5'h16, 5'h18, 5'h1a,
		5'h1c, 5'h1f};
	logic [3:0] microstep_resolution_code_tab[4] = '{4'h5, 4'h4, 4'h3, 4'h2};
	int err_count, compares;

	ssc_board_model ssc_board_model_inst (.clock(clock),
		.strap_level(strap_level), .ext_run(ext_run), .strap_pins(sp),
		.ext_clk_pin(ext_clk_pin));
	ssc_strap_config ssc_strap_config_inst (.clock(clock), .reset_n(reset_n),
		.serial_select_pin(serial_select_pin),
		.step_dir_mode_pin(step_dir_mode_pin), .strap_pin_0(sp[0]),
		.strap_pin_1(sp[1]), .strap_pin_2(sp[2]), .strap_pin_3(sp[3]),
		.strap_pin_4(sp[4]), .strap_pin_5(sp[5]), .strap_pin_6(sp[6]),
		.ext_clk_pin(ext_clk_pin), .serial_cfg_valid(serial_cfg_valid),
		.serial_cfg(serial_cfg), .serial_diagnostic_output_enable(serial_diagnostic_output_enable),
		.active_cfg(active_cfg), .standalone_mode(standalone_mode),
		.spi_enable(spi_enable), .uart_enable(uart_enable),
		.ramp_generator_enable(ramp_generator_enable),
		.diagnostic_output_output_enable(diagnostic_output_output_enable),
		.use_external_clock(use_external_clock));

	// ----------------------------------------------------------------
	// Clock, checks and verdict
	// ----------------------------------------------------------------
	// Core clock at 40 MHz.
	initial
		clock = 1'b0;
	always #12.5 clock = ~clock;

	task automatic chk(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		if (err_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Waits a bounded time for the clock select to reach a level.
	task automatic wait_ext(input logic lvl, input int lim);
		for (int n = 0; n < lim && use_external_clock !== lvl; n++)
			@(negedge clock);
	endtask

	// The whole run takes about 140 cycles; this is a generous margin.
	initial
	begin
		#50000;
		err_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	// Inputs change on falling edges only.
	initial
	begin
		{serial_select_pin, step_dir_mode_pin, ext_run} = 3'h0;
		{serial_cfg_valid, serial_diagnostic_output_enable, reset_n} = 3'h0;
		{strap_level, serial_cfg, err_count, compares} = '0;
		repeat (4) @(negedge clock);
		reset_n = 1'b1;
		chk("microstep_resolution_code", active_cfg.microstep_resolution_code, 4'h0);
		chk("run_current_scale", active_cfg.run_current_scale, 5'h1f);
		chk("hold_current_scale", active_cfg.hold_current_scale, 5'h10);
		chk("diagnostic_output", diagnostic_output_output_enable, 1'b0);
		chk("chopper_off_time", active_cfg.chopper_off_time, 4'h0);
		chk("pwm", active_cfg.pwm_mode_enable, 1'b0);
		chk("clk", use_external_clock, 1'b0);
		{serial_cfg_valid, serial_diagnostic_output_enable} = 2'h3;
		@(negedge clock);
		serial_cfg_valid = 1'b0;
		// Order 2,3,0,1 ends in standalone, the only selecting pair.
		for (int k = 0; k < 4; k++)
		begin
			{serial_select_pin, step_dir_mode_pin} = 2'(k ^ 2);
			repeat (2) @(negedge clock);
			chk("sa", standalone_mode, 1'(k == 3));
			chk("spi", spi_enable, 1'(k != 3));
			chk("uart", uart_enable, 1'(k != 3));
			chk("ramp", ramp_generator_enable, 1'(k != 3));
		end
		chk("diagnostic_output", diagnostic_output_output_enable, 1'b1);
		// Rows pair each strap code with the setting it must give.
		for (int i = 0; i < 8; i++)
		begin
			rows[i].strap = {i[1], i[0], 3'(i), i[1:0]};
			rows[i].exp = {microstep_resolution_code_tab[i[1:0]], run_current_scale_tab[i],
				i[1] ? run_current_scale_tab[i] >> 1 : run_current_scale_tab[i], 4'h3, i[0]};
		end
		foreach (rows[i])
		begin
			strap_level = rows[i].strap;
			repeat (4) @(negedge clock);
			chk("microstep_resolution_code", active_cfg.microstep_resolution_code,
				rows[i].exp.microstep_resolution_code);
			chk("run_current_scale", active_cfg.run_current_scale,
				rows[i].exp.run_current_scale);
			chk("hold_current_scale", active_cfg.hold_current_scale,
				rows[i].exp.hold_current_scale);
			chk("pwm", active_cfg.pwm_mode_enable, 1'(i[0]));
			if (!i[0])
				chk("chopper_off_time", active_cfg.chopper_off_time, 4'h3);
		end
		// Serial traffic in standalone must change nothing.
		{serial_cfg, serial_cfg_valid, serial_diagnostic_output_enable} = {19'h7_ffff, 2'h2};
		repeat (2) @(negedge clock);
		serial_cfg_valid = 1'b0;
		chk("microstep_resolution_code", active_cfg.microstep_resolution_code, 4'h2);
		chk("diagnostic_output", diagnostic_output_output_enable, 1'b1);
		ext_run = 1'b1;
		repeat (5) @(negedge clock);
		chk("ext1", use_external_clock, 1'b0);
		wait_ext(1'b1, 12);
		chk("ext2", use_external_clock, 1'b1);
		repeat (40) @(negedge clock);
		chk("extrun", use_external_clock, 1'b1);
		ext_run = 1'b0;
		repeat (24) @(negedge clock);
		chk("wdhold", use_external_clock, 1'b1);
		wait_ext(1'b0, 16);
		chk("wdback", use_external_clock, 1'b0);
		{serial_select_pin, step_dir_mode_pin, strap_level} = '0;
		reset_n = 1'b0;
		@(negedge clock);
		chk("microstep_resolution_code", active_cfg.microstep_resolution_code, 4'h0);
		chk("sa", standalone_mode, 1'b0);
		chk("clkrst", use_external_clock, 1'b0);
		// Second release of reset with all pins low.
		reset_n = 1'b1;
		repeat (2) @(negedge clock);
		chk("sa2", standalone_mode, 1'b0);
		chk("spi2", spi_enable, 1'b1);
		chk("clk2", use_external_clock, 1'b0);
		chk("irun2", active_cfg.run_current_scale, 5'h1f);
		summarize();
	end
endmodule
